// ===== fan_ctrl_pkg.sv
package fan_ctrl_pkg;

    // ****************************************
    // Register map and reset values
    // ****************************************
    localparam logic [1:0] REG_TARGET_IDX = 2'h0;
    localparam logic [1:0] REG_MEASURED_IDX = 2'h1;
    localparam logic [1:0] REG_FLAGS_IDX = 2'h2;
    localparam logic [7:0] TARGET_RESET = 8'hff;
    localparam logic [7:0] MEASURED_RESET = 8'hff;
    localparam logic [7:0] FLAGS_RESET = 8'h02;
    localparam int FLAG_DEVIATION_BIT = 0;
    localparam int FLAG_LOW_SPEED_BIT = 1;

    // ****************************************
    // Speed control constants
    // ****************************************
    localparam logic [7:0] STOP_CODE = 8'hff;
    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] LOW_SPEED_COUNT = 8'hff;
    localparam logic [7:0] DEV_BAND_MUL = 8'h05;
    localparam logic [7:0] REG_BAND_MUL = 8'h32;

    // ****************************************
    // Serial bus constants
    // ****************************************
    localparam logic [7:0] SMB_ADDR_WR = 8'h7c;
    localparam logic [7:0] SMB_ADDR_RD = 8'h7d;
    localparam logic [3:0] BIT_ACK_SLOT = 4'h8;
    localparam logic [3:0] BIT_ACK_DONE = 4'h9;

    typedef struct packed {
        logic start;
        logic stop;
        logic byte_done;
        logic nack;
        logic [7:0] data;
    } smb_evt_s;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_ADDR = 6'b000010,
        ST_CMD = 6'b000100,
        ST_DATA = 6'b001000,
        ST_READ = 6'b010000,
        ST_IGNORE = 6'b100000
    } smb_state_e;

endpackage

// ===== fan_tacho_meter.sv
`timescale 1ns/1ns
`default_nettype none
module fan_tacho_meter (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_tacho_pulse_in,
    output logic [7:0] o_count,
    output logic o_toggle
);
    import fan_ctrl_pkg::*;

    logic rst_s1, rst_s2;
    logic tacho_s1, tacho_s2, tacho_s3;
    logic [7:0] cnt_reg, cnt_next;
    logic [7:0] count_reg, count_next;
    logic toggle_reg, toggle_next;
    logic edge_seen, sat_hit;

    // ****************************************
    // Reset release and pin synchroniser
    // ****************************************
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            rst_s1 <= 1'b1;
            rst_s2 <= 1'b1;
            tacho_s1 <= 1'b0;
            tacho_s2 <= 1'b0;
            tacho_s3 <= 1'b0;
        end else begin
            rst_s1 <= 1'b0;
            rst_s2 <= rst_s1;
            tacho_s1 <= i_tacho_pulse_in;
            tacho_s2 <= tacho_s1;
            tacho_s3 <= tacho_s2;
        end
    end

    // ****************************************
    // Period counter
    // ****************************************
    always_comb begin
        edge_seen = tacho_s2 & ~tacho_s3;
        sat_hit = ~edge_seen & (cnt_reg == COUNT_MAX - 8'h01);
        cnt_next = cnt_reg;
        count_next = count_reg;
        toggle_next = toggle_reg;
        if (edge_seen) begin
            cnt_next = 8'h01; // RQ1
            count_next = cnt_reg; // RQ1
            toggle_next = ~toggle_reg;
        end else if (cnt_reg != COUNT_MAX) begin
            cnt_next = cnt_reg + 8'h01; // RQ14
        end
        // Stalled fan reports at once, not at the next edge
        if (sat_hit) begin
            count_next = COUNT_MAX; // RQ14
            toggle_next = ~toggle_reg;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_reg <= 8'h00;
            count_reg <= MEASURED_RESET;
            toggle_reg <= 1'b0;
        end else if (rst_s2) begin
            cnt_reg <= 8'h00;
            count_reg <= MEASURED_RESET;
            toggle_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            count_reg <= count_next;
            toggle_reg <= toggle_next;
        end
    end

    assign o_count = count_reg;
    assign o_toggle = toggle_reg;

    a_count_saturates: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (cnt_reg == COUNT_MAX) && !edge_seen && !rst_s2 |=> cnt_reg == COUNT_MAX) // RQ14
        else $error("period counter wrapped");

    a_edge_publish: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        edge_seen && !rst_s2 |=> o_count == $past(cnt_reg) && o_toggle != $past(o_toggle)) // RQ1
        else $error("period not published on tacho edge");

endmodule
`default_nettype wire

// ===== fan_smbus_engine.sv
`timescale 1ns/1ns
`default_nettype none
module fan_smbus_engine (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_ack,
    input wire logic i_tx_en,
    input wire logic [7:0] i_tx_byte,
    output fan_ctrl_pkg::smb_evt_s o_evt,
    output logic o_sda_en_n
);
    import fan_ctrl_pkg::*;

    logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
    logic scl_rise, scl_fall, start_seen, stop_seen;
    logic active_reg, active_next, tx_reg, tx_next;
    logic en_n_reg, en_n_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] sh_reg, sh_next;
    smb_evt_s evt_reg, evt_next;

    // ****************************************
    // Bit level engine
    // ****************************************
    always_comb begin
        scl_rise = scl_s2 & ~scl_s3;
        scl_fall = ~scl_s2 & scl_s3;
        start_seen = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
        stop_seen = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
        active_next = active_reg;
        tx_next = tx_reg;
        en_n_next = en_n_reg;
        cnt_next = cnt_reg;
        sh_next = sh_reg;
        evt_next = '0;
        if (start_seen || stop_seen) begin
            active_next = start_seen;
            tx_next = 1'b0;
            en_n_next = 1'b1;
            cnt_next = 4'h0;
            evt_next.start = start_seen;
            evt_next.stop = stop_seen;
        end else if (active_reg && scl_rise) begin
            if (cnt_reg < BIT_ACK_SLOT) begin
                sh_next = {sh_reg[6:0], sda_s2};
                cnt_next = cnt_reg + 4'h1;
                evt_next.byte_done = (cnt_reg == BIT_ACK_SLOT - 4'h1);
                evt_next.data = {sh_reg[6:0], sda_s2};
            end else if (cnt_reg == BIT_ACK_SLOT) begin
                cnt_next = BIT_ACK_DONE;
                evt_next.nack = tx_reg & sda_s2;
            end
        end else if (active_reg && scl_fall) begin
            // Data only changes while the clock is low
            if (cnt_reg == BIT_ACK_SLOT) begin
                en_n_next = tx_reg | ~i_ack;
            end else if (cnt_reg == BIT_ACK_DONE) begin
                cnt_next = 4'h0;
                tx_next = i_tx_en;
                sh_next = i_tx_byte;
                en_n_next = ~i_tx_en | i_tx_byte[7];
            end else if (tx_reg) begin
                en_n_next = sh_reg[7];
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_s3 <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_s3 <= 1'b1;
            active_reg <= 1'b0;
            tx_reg <= 1'b0;
            en_n_reg <= 1'b1;
            cnt_reg <= 4'h0;
            sh_reg <= 8'h00;
            evt_reg <= '0;
        end else begin
            scl_s1 <= i_scl;
            scl_s2 <= scl_s1;
            scl_s3 <= scl_s2;
            sda_s1 <= i_sda;
            sda_s2 <= sda_s1;
            sda_s3 <= sda_s2;
            active_reg <= active_next;
            tx_reg <= tx_next;
            en_n_reg <= en_n_next;
            cnt_reg <= cnt_next;
            sh_reg <= sh_next;
            evt_reg <= evt_next;
        end
    end

    assign o_evt = evt_reg;
    assign o_sda_en_n = en_n_reg;

endmodule
`default_nettype wire

// ===== fan_speed_closed_loop_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// [RQ1] Speed is reference periods between tacho rises
// [RQ2] Host writes count 30*clk/(rpm*pulses)
// [RQ3] Duty trimmed to hold speed within 2%
// [RQ4] Run pin high regulates to target count
// [RQ5] Run low or target 255 stops fan
// [RQ6] Either stop condition enters power saving
// [RQ7] Target count at index 0, RW, reset FFh
// [RQ8] Measured count at index 1, read only
// [RQ9] Status bit0 flags deviation beyond 20%
// [RQ10] Status bit1 flags speed below 1920 rpm
// [RQ11] Status reads binary 10 after power-up
// [RQ12] Answer address bytes 7Ch write, 7Dh read
// [RQ13] Byte-data transfers; read-only writes ignored
// [RQ14] Period counter saturates at 255
module fan_speed_closed_loop_ctrl #(
    parameter int PWM_BITS = 8
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_ref_clk,
    input wire logic i_tacho_pulse_in,
    input wire logic i_run,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_en_n,
    output logic o_fan_drive,
    output logic o_power_save
);
    import fan_ctrl_pkg::*;

    logic [7:0] tacho_count;
    logic tacho_toggle;
    logic tog_s1, tog_s2, tog_s3;
    logic run_s1, run_s2;
    logic meas_new;
    fan_ctrl_pkg::smb_evt_s evt;

    smb_state_e state_reg, state_next;
    logic [1:0] ptr_reg, ptr_next;
    logic ack_reg, ack_next;
    logic tx_en_reg, tx_en_next;
    logic [7:0] tx_byte_reg, tx_byte_next;
    logic [7:0] read_mux;
    logic wr_target;

    logic [7:0] target_reg, target_next;
    logic [7:0] measured_reg, measured_next;
    logic [7:0] flags_reg, flags_next;
    logic upd_reg, upd_next;

    logic [PWM_BITS-1:0] duty_reg, duty_next;
    logic [PWM_BITS-1:0] pwm_cnt_reg, pwm_cnt_next;
    logic drive_reg, drive_next;
    logic save_reg, save_next;
    logic stop_now, too_slow, too_fast, dev_out;
    logic [7:0] err_abs;
    logic [15:0] err_reg_band, err_dev_band;

    // ****************************************
    // Leaf blocks
    // ****************************************
    fan_tacho_meter u_tacho (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_tacho_pulse_in(i_tacho_pulse_in),
        .o_count(tacho_count),
        .o_toggle(tacho_toggle)
    );

    fan_smbus_engine u_smb (
        .i_clk(i_core_clk),
        .i_rst(i_rst),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .i_ack(ack_reg),
        .i_tx_en(tx_en_reg),
        .i_tx_byte(tx_byte_reg),
        .o_evt(evt),
        .o_sda_en_n(o_sda_en_n)
    );

    // ****************************************
    // Crossings into the core clock
    // ****************************************
    // Count is held steady in the reference domain long after the toggle
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_s3 <= 1'b0;
            run_s1 <= 1'b0;
            run_s2 <= 1'b0;
        end else begin
            tog_s1 <= tacho_toggle;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
            run_s1 <= i_run;
            run_s2 <= run_s1;
        end
    end

    assign meas_new = tog_s2 ^ tog_s3;

    // ****************************************
    // Transaction decoder
    // ****************************************
    always_comb begin
        unique case (ptr_reg)
            REG_TARGET_IDX: read_mux = target_reg;
            REG_MEASURED_IDX: read_mux = measured_reg;
            REG_FLAGS_IDX: read_mux = flags_reg;
            default: read_mux = 8'h00;
        endcase
    end

    always_comb begin
        state_next = state_reg;
        ptr_next = ptr_reg;
        ack_next = ack_reg;
        tx_en_next = tx_en_reg;
        tx_byte_next = tx_byte_reg;
        wr_target = 1'b0;
        if (evt.stop) begin
            state_next = ST_IDLE;
            ack_next = 1'b0;
            tx_en_next = 1'b0;
        end else if (evt.start) begin
            state_next = ST_ADDR;
            ack_next = 1'b0;
            tx_en_next = 1'b0;
        end else if (evt.nack) begin
            state_next = ST_IGNORE;
            tx_en_next = 1'b0;
        end else if (evt.byte_done) begin
            unique case (state_reg)
                ST_ADDR: begin
                    if (evt.data == SMB_ADDR_WR) begin // RQ12
                        state_next = ST_CMD;
                        ack_next = 1'b1;
                    end else if (evt.data == SMB_ADDR_RD) begin // RQ12
                        state_next = ST_READ;
                        ack_next = 1'b1;
                        tx_en_next = 1'b1;
                        tx_byte_next = read_mux;
                    end else begin
                        state_next = ST_IGNORE;
                        ack_next = 1'b0;
                    end
                end
                ST_CMD: begin
                    ptr_next = evt.data[1:0]; // RQ13
                    state_next = ST_DATA;
                end
                ST_DATA: begin
                    // Read-only indices still ack but keep their value
                    wr_target = (ptr_reg == REG_TARGET_IDX); // RQ13
                end
                ST_READ: begin
                    tx_byte_next = read_mux;
                end
                ST_IDLE, ST_IGNORE: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= ST_IDLE;
            ptr_reg <= REG_TARGET_IDX;
            ack_reg <= 1'b0;
            tx_en_reg <= 1'b0;
            tx_byte_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            ptr_reg <= ptr_next;
            ack_reg <= ack_next;
            tx_en_reg <= tx_en_next;
            tx_byte_reg <= tx_byte_next;
        end
    end

    // ****************************************
    // Registers and status flags
    // ****************************************
    always_comb begin
        err_abs = (measured_reg >= target_reg) ?
            measured_reg - target_reg : target_reg - measured_reg;
        err_dev_band = 16'(err_abs) * 16'(DEV_BAND_MUL);
        err_reg_band = 16'(err_abs) * 16'(REG_BAND_MUL);
        dev_out = err_dev_band > 16'(target_reg);
        target_next = wr_target ? evt.data : target_reg; // RQ7
        measured_next = meas_new ? tacho_count : measured_reg; // RQ8
        upd_next = meas_new;
        flags_next = 8'h00;
        flags_next[FLAG_DEVIATION_BIT] = dev_out; // RQ9
        // Counter saturates at 255, which is the 1920 rpm boundary
        flags_next[FLAG_LOW_SPEED_BIT] = measured_reg >= LOW_SPEED_COUNT; // RQ10
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            target_reg <= TARGET_RESET; // RQ7
            measured_reg <= MEASURED_RESET;
            flags_reg <= FLAGS_RESET; // RQ11
            upd_reg <= 1'b0;
        end else begin
            target_reg <= target_next;
            measured_reg <= measured_next;
            flags_reg <= flags_next;
            upd_reg <= upd_next;
        end
    end

    // ****************************************
    // Speed loop and PWM
    // ****************************************
    // One duty step per measurement keeps the loop slow and stable
    always_comb begin
        stop_now = ~run_s2 | (target_reg == STOP_CODE); // RQ5
        too_slow = (measured_reg > target_reg) &&
            (err_reg_band > 16'(target_reg));
        too_fast = (measured_reg < target_reg) &&
            (err_reg_band > 16'(target_reg));
        duty_next = duty_reg;
        if (stop_now) begin
            duty_next = '0; // RQ5
        end else if (upd_reg && too_slow && !(&duty_reg)) begin
            duty_next = duty_reg + 1'b1; // RQ3 RQ4
        end else if (upd_reg && too_fast && (|duty_reg)) begin
            duty_next = duty_reg - 1'b1; // RQ3 RQ4
        end
        pwm_cnt_next = pwm_cnt_reg + 1'b1;
        drive_next = ~stop_now && (pwm_cnt_reg < duty_reg); // RQ5
        save_next = stop_now; // RQ6
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            duty_reg <= '0;
            pwm_cnt_reg <= '0;
            drive_reg <= 1'b0;
            save_reg <= 1'b1;
        end else begin
            duty_reg <= duty_next;
            pwm_cnt_reg <= pwm_cnt_next;
            drive_reg <= drive_next;
            save_reg <= save_next;
        end
    end

    assign o_fan_drive = drive_reg;
    assign o_power_save = save_reg;

    // ****************************************
    // Checks
    // ****************************************
    a_stop_no_drive: assert property (@(posedge i_core_clk) disable iff (i_rst)
        stop_now |=> !o_fan_drive && o_power_save) // RQ5
        else $error("fan driven while stopped");

    a_save_follows: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $fell(stop_now) |=> !o_power_save ##1
        (o_power_save == $past(stop_now))) // RQ6
        else $error("power saving not left after restart");

    a_loop_slow_up: assert property (@(posedge i_core_clk) disable iff (i_rst)
        upd_reg && !stop_now && too_slow && !(&duty_reg)
        |=> duty_reg == PWM_BITS'($past(duty_reg) + 1'b1)) // RQ3
        else $error("duty not raised for slow fan");

    a_loop_fast_down: assert property (@(posedge i_core_clk) disable iff (i_rst)
        upd_reg && !stop_now && too_fast && (|duty_reg)
        |=> duty_reg == PWM_BITS'($past(duty_reg) - 1'b1)) // RQ4
        else $error("duty not lowered for fast fan");

    a_target_write: assert property (@(posedge i_core_clk) disable iff (i_rst)
        evt.byte_done && state_reg == ST_DATA && ptr_reg == REG_TARGET_IDX
        |=> target_reg == $past(evt.data)) // RQ7
        else $error("target count not written");

    a_ro_ignored: assert property (@(posedge i_core_clk) disable iff (i_rst)
        evt.byte_done && state_reg == ST_DATA && ptr_reg != REG_TARGET_IDX
        |=> $stable(target_reg)) // RQ13
        else $error("read-only write changed target");

    a_meas_capture: assert property (@(posedge i_core_clk) disable iff (i_rst)
        meas_new |=> measured_reg == $past(tacho_count) ##1 upd_reg == 1'b0) // RQ8
        else $error("measured count not captured");

    a_dev_flag: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $stable(measured_reg) && $stable(target_reg)
        |-> flags_reg[0] == ((16'($past(err_abs)) * 16'h0005)
            > 16'($past(target_reg)))) // RQ9
        else $error("deviation flag wrong");

    a_low_flag: assert property (@(posedge i_core_clk) disable iff (i_rst)
        measured_reg == 8'hff |=> flags_reg[1] == 1'b1) // RQ10
        else $error("low speed flag missing");

    a_addr_reject: assert property (@(posedge i_core_clk) disable iff (i_rst)
        evt.byte_done && state_reg == ST_ADDR && evt.data != 8'h7c
        && evt.data != 8'h7d |=> state_reg == ST_IGNORE && !ack_reg) // RQ12
        else $error("foreign address accepted");

    c_stop_by_code: cover property (@(posedge i_core_clk) disable iff (i_rst)
        run_s2 && target_reg == 8'hff && o_power_save);
    c_target_write: cover property (@(posedge i_core_clk) disable iff (i_rst)
        wr_target);
    c_read_start: cover property (@(posedge i_core_clk) disable iff (i_rst)
        state_reg == ST_READ && tx_en_reg);
    c_deviation: cover property (@(posedge i_core_clk) disable iff (i_rst)
        flags_reg[0] && o_fan_drive);

endmodule
`default_nettype wire

// ===== fan_tacho_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Fan with tacho output, reference domain
// ****************************************
module fan_tacho_model (
    input wire logic i_ref_clk,
    input wire logic i_spin,
    input wire logic [7:0] i_period,
    output logic o_tacho
);
    logic [7:0] cnt = 8'h00;
    // Stopped fan gives no edges, line held low
    always @(posedge i_ref_clk) begin
        if (!i_spin) begin
            cnt <= 8'h00;
            o_tacho <= 1'b0;
        end else begin
            cnt <= (cnt == i_period - 8'h01) ? 8'h00 : cnt + 8'h01;
            o_tacho <= (cnt < (i_period >> 1));
        end
    end
endmodule
`default_nettype wire

// ===== fan_speed_closed_loop_ctrl_test.sv
`timescale 1ns/1ns
`default_nettype none
module fan_speed_closed_loop_ctrl_test;
    import fan_ctrl_pkg::*;
    logic core_clk = 0, ref_clk = 0, rst = 1, run = 1;
    logic scl = 1, sda_m = 1, spin = 0, ack;
    logic [7:0] period = 8'h32;
    wire sda_w, en_n, drive, psave, tacho;
    int n_mismatch = 0, compares = 0, cyc = 0, hi;
    // Open-drain wire, pulled up
    assign sda_w = sda_m & en_n;
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    // Unrelated phase to the core clock
    initial begin
        #37;
        forever #80 ref_clk = ~ref_clk;
    end
    fan_speed_closed_loop_ctrl i_dut (.i_core_clk(core_clk), .i_rst(rst),
        .i_ref_clk(ref_clk), .i_tacho_pulse_in(tacho), .i_run(run),
        .i_scl(scl), .i_sda(sda_w), .o_sda_en_n(en_n),
        .o_fan_drive(drive), .o_power_save(psave));
    fan_tacho_model i_fan (.i_ref_clk(ref_clk), .i_spin(spin),
        .i_period(period), .o_tacho(tacho));
    // ****************************************
    // Bus tasks
    // ****************************************
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
            input string what);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // SDA moves only while SCL low, away from the fall
    task automatic sbit(input logic b, output logic r);
        sda_m = b;
        tick(10);
        scl = 1;
        tick(5);
        r = sda_w;
        tick(5);
        scl = 0;
        tick(2);
    endtask
    task automatic sstart();
        sda_m = 1;
        tick(10);
        scl = 1;
        tick(10);
        sda_m = 0;
        tick(10);
        scl = 0;
        tick(2);
    endtask
    task automatic sstop();
        sda_m = 0;
        tick(10);
        scl = 1;
        tick(10);
        sda_m = 1;
        tick(10);
    endtask
    task automatic sbyte(input logic [7:0] b, output logic a);
        logic r;
        for (int i = 7; i >= 0; i--) sbit(b[i], r);
        sbit(1'b1, r);
        a = ~r;
    endtask
    task automatic wr(input logic [1:0] idx, input logic [7:0] d);
        logic a;
        sstart();
        sbyte(SMB_ADDR_WR, a);
        sbyte({6'h00, idx}, a);
        sbyte(d, a);
        sstop();
    endtask
    task automatic rchk(input logic [1:0] idx, input logic [7:0] exp,
            input string what);
        logic a;
        logic r;
        logic [7:0] d;
        sstart();
        sbyte(SMB_ADDR_WR, a);
        sbyte({6'h00, idx}, a);
        sstart();
        sbyte(SMB_ADDR_RD, a);
        for (int i = 7; i >= 0; i--) begin
            sbit(1'b1, r);
            d[i] = r;
        end
        sbit(1'b1, r);
        sstop();
        chk(d, exp, what);
    endtask
    task automatic count_hi();
        hi = 0;
        repeat (256) begin
            tick(1);
            if (drive === 1'b1) hi++;
        end
    endtask
    task automatic summarize();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Ceiling well above the roughly 39k cycles the tests need
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 80000) begin
            n_mismatch++;
            summarize();
        end
    end
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        tick(6);
        repeat (2) @(posedge ref_clk);
        // Release off both clock edges, never racing the async reset
        tick(1);
        rst = 0;
        tick(4);
        rchk(REG_TARGET_IDX, TARGET_RESET, "target reset");
        rchk(REG_FLAGS_IDX, FLAGS_RESET, "flags reset");
        chk({7'h00, psave}, 8'h01, "saving at ff");
        sstart();
        sbyte(8'h7e, ack);
        sstop();
        chk({7'h00, ack}, 8'h00, "foreign addr");
        $display("test reset done");
        wr(REG_TARGET_IDX, 8'h40);
        wr(REG_FLAGS_IDX, 8'h00);
        wr(REG_MEASURED_IDX, 8'h11);
        rchk(REG_TARGET_IDX, 8'h40, "target rw");
        rchk(REG_MEASURED_IDX, MEASURED_RESET, "measured ro");
        rchk(REG_FLAGS_IDX, 8'h03, "flags ro");
        rchk(2'h3, 8'h00, "unused index");
        $display("test access done");
        spin = 1;
        tick(6000);
        rchk(REG_MEASURED_IDX, 8'h32, "period count");
        rchk(REG_FLAGS_IDX, 8'h01, "deviation");
        chk({7'h00, psave}, 8'h00, "running");
        // Slow fan against target 40 must raise duty
        wr(REG_TARGET_IDX, 8'h28);
        tick(6000);
        count_hi();
        chk({7'h00, hi > 0}, 8'h01, "duty raised");
        wr(REG_TARGET_IDX, 8'h32);
        rchk(REG_FLAGS_IDX, 8'h00, "on target");
        $display("test measure done");
        run = 0;
        tick(6);
        count_hi();
        chk({7'h00, psave}, 8'h01, "pin stop");
        chk(8'(hi), 8'h00, "pin stop drive");
        run = 1;
        tick(6);
        chk({7'h00, psave}, 8'h00, "pin run");
        wr(REG_TARGET_IDX, STOP_CODE);
        tick(6);
        count_hi();
        chk({7'h00, psave}, 8'h01, "code stop");
        chk(8'(hi), 8'h00, "code stop drive");
        $display("test stop done");
        spin = 0;
        tick(12000);
        rchk(REG_MEASURED_IDX, COUNT_MAX, "saturated");
        rchk(REG_FLAGS_IDX, 8'h02, "low speed");
        $display("test saturate done");
        summarize();
    end
endmodule
`default_nettype wire
